// file: rtl/rsf_cfg_reg.sv
// one config register with a writable mask and fixed reserved bits
`timescale 1ns/1ps
module rsf_cfg_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0,
  parameter logic [W-1:0] WMASK = '1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] value_reg
);

  logic [W-1:0] value_next; // masked merge of write data

  // reserved bits keep their reset value whatever is written
  always_comb begin
    value_next = (value_reg & ~WMASK) | (wdata & WMASK);
  end

  // storage, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_reg <= RESET_VAL;
    end else if (ce && wr_en) begin
      value_reg <= value_next;
    end
  end

endmodule : rsf_cfg_reg

// file: rtl/rsf_defs.svh
// register indices, field positions, reset values of the rx config bank
`ifndef RSF_DEFS_SVH
`define RSF_DEFS_SVH

// register indices; byte address is index times four
`define RSF_IDX_PFC 8'h11
`define RSF_IDX_SYNC 8'h12
`define RSF_IDX_RESV 8'h13
`define RSF_IDX_PAT 8'h20

// address bits that hold the word index
`define RSF_ADDR_IDX_HI 9
`define RSF_ADDR_IDX_LO 2

// reset values
`define RSF_RST_PFC 8'h38
`define RSF_RST_SYNC 8'h18
`define RSF_RST_RESV 8'h07
`define RSF_RST_PAT 32'h0000_0000

// writable bit masks; reserved bits hold their reset value
`define RSF_WMASK_PFC 8'hf0
`define RSF_WMASK_SYNC 8'hfe
`define RSF_WMASK_RESV 8'h00

// polyphase filter register fields
`define RSF_PFC_CFV_HI 7
`define RSF_PFC_CFV_LO 4

// sync control register fields
`define RSF_SYNC_POLEN 7
`define RSF_SYNC_BSOFF 6
`define RSF_SYNC_DETON 5
`define RSF_SYNC_LEN_HI 4
`define RSF_SYNC_LEN_LO 3
`define RSF_SYNC_TOL_HI 2
`define RSF_SYNC_TOL_LO 1

// ahb encodings
`define RSF_HTRANS_NSEQ_BIT 1
`define RSF_HRESP_OKAY 1'b0

`endif

// file: rtl/rsf_pattern_match.sv
// sliding sync pattern comparator with error tolerance
`timescale 1ns/1ps
module rsf_pattern_match #(
  parameter int PW = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic detect_on,
  input wire logic [1:0] length_sel,
  input wire logic [1:0] tolerance,
  input wire logic [PW-1:0] pattern,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  output logic match_reg
);

  logic [PW-1:0] hist_reg; // newest bit in bit 0
  logic [PW-1:0] hist_next;
  logic [PW-1:0] len_mask; // bits taking part in the compare
  logic [5:0] err_cnt; // differing bits within the mask
  logic [PW-1:0] diff;

  // history shifts only on a received bit
  always_comb begin
    hist_next = {hist_reg[PW-2:0], rx_bit};
  end

  // length code picks 8, 16, 24 or 32 compared bits
  always_comb begin
    unique case (rsf_pkg::rsf_len_t'(length_sel))
      rsf_pkg::RSF_LEN_8: len_mask = PW'(32'h0000_00ff);
      rsf_pkg::RSF_LEN_16: len_mask = PW'(32'h0000_ffff);
      rsf_pkg::RSF_LEN_24: len_mask = PW'(32'h00ff_ffff);
      rsf_pkg::RSF_LEN_32: len_mask = PW'(32'hffff_ffff);
    endcase
  end

  // popcount of mismatches over the selected window
  always_comb begin
    diff = (hist_next ^ pattern) & len_mask;
    err_cnt = 6'h00;
    for (int i = 0; i < PW; i++) begin
      err_cnt = err_cnt + {5'h00, diff[i]};
    end
  end

  // bit history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_reg <= '0;
    end else if (ce && rx_bit_valid) begin
      hist_reg <= hist_next;
    end
  end

  // one-cycle match pulse per received bit within tolerance
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_reg <= 1'b0;
    end else if (ce) begin
      match_reg <= detect_on && rx_bit_valid &&
                   (err_cnt <= {4'h0, tolerance});
    end
  end

endmodule : rsf_pattern_match

// file: rtl/rsf_pkg.sv
// types shared by the rx config bank
package rsf_pkg;

  // bus data phase in progress
  typedef enum logic [1:0] {
    RSF_PH_IDLE = 2'b00,
    RSF_PH_WRITE = 2'b01,
    RSF_PH_READ = 2'b10
  } rsf_phase_t;

  // compared pattern length codes
  typedef enum logic [1:0] {
    RSF_LEN_8 = 2'b00,
    RSF_LEN_16 = 2'b01,
    RSF_LEN_24 = 2'b10,
    RSF_LEN_32 = 2'b11
  } rsf_len_t;

endpackage : rsf_pkg

// file: rtl/rsf_rx_sync_filter_config.sv
// ahb-lite register bank for the rx polyphase filter and sync word setup
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "rsf_defs.svh"
module rsf_rx_sync_filter_config #(
  parameter int AW = 12,
  parameter int PW = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave port
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // receive bit stream
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  // configuration seen by the rf path
  output logic [3:0] poly_centre_freq_value,
  output logic ook_poly_filter_on,
  output logic bit_synchronizer_off_n,
  output logic bit_sync_active,
  output logic pattern_detect_on,
  output logic [1:0] pattern_length_sel,
  output logic [1:0] pattern_error_tolerance,
  output logic pattern_match
);

  // register contents
  logic [7:0] polyphase_filter_config_reg;
  logic [7:0] sync_word_control_reg;
  logic [7:0] reserved_config_reg;
  logic [PW-1:0] sync_pattern_reg;

  // bus tracking
  rsf_pkg::rsf_phase_t phase_reg; // data phase kind
  logic [7:0] idx_reg; // word index latched in address phase
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic hreadyout_reg;
  logic hresp_reg;

  // decoded write strobes
  logic wr_pfc;
  logic wr_sync;
  logic wr_resv;
  logic wr_pat;

  // flopped copies of the config fields
  logic [3:0] cfv_out_reg;
  logic polen_out_reg;
  logic bsoff_out_reg;
  logic bsact_out_reg;
  logic deton_out_reg;
  logic [1:0] len_out_reg;
  logic [1:0] tol_out_reg;

  // address phase decode results
  logic addr_take; // valid address phase this cycle
  logic wr_take; // write address phase taken
  logic rd_take; // read address phase taken
  logic [7:0] addr_idx; // word index of the address phase

  // reset images of the field copies, taken from the register resets
  // so that the two can never drift apart
  localparam logic [7:0] PFC_RST = `RSF_RST_PFC;
  localparam logic [7:0] SYNC_RST = `RSF_RST_SYNC;

  // address phase decode
  // one word per register, so the byte lane bits play no part
  // hsize is not decoded: only whole-word transfers are expected

  // only nonseq/seq transfers with hready high start a data phase
  always_comb begin
    addr_take = hsel && hready && htrans[`RSF_HTRANS_NSEQ_BIT];
    wr_take = addr_take && hwrite;
    rd_take = addr_take && !hwrite;
    addr_idx = haddr[`RSF_ADDR_IDX_HI:`RSF_ADDR_IDX_LO];
  end

  // data phase kind; reads take one wait state for a clean value
  // a read never overlaps a new address: the master waits on ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= rsf_pkg::RSF_PH_IDLE;
    end else if (ce) begin
      unique case (phase_reg)
        rsf_pkg::RSF_PH_READ: begin
          // wait state over, bus is held so nothing new arrives
          phase_reg <= rsf_pkg::RSF_PH_IDLE;
        end
        default: begin
          // idle or write data phase: accept a new address
          if (wr_take) begin
            phase_reg <= rsf_pkg::RSF_PH_WRITE;
          end else if (rd_take) begin
            phase_reg <= rsf_pkg::RSF_PH_READ;
          end else begin
            phase_reg <= rsf_pkg::RSF_PH_IDLE;
          end
        end
      endcase
    end
  end

  // index of the register addressed; low address bits ignored
  // the read wait state keeps the index of the pending read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_reg <= 8'h00;
    end else if (ce && addr_take && phase_reg != rsf_pkg::RSF_PH_READ) begin
      idx_reg <= addr_idx;
    end
  end

  // write path
  // reserved bits are masked inside each register, not here

  // strobes fire during the write data phase, hwdata is valid then
  // one strobe per register; an unmapped index writes nothing
  always_comb begin
    wr_pfc = (phase_reg == rsf_pkg::RSF_PH_WRITE) &&
             (idx_reg == `RSF_IDX_PFC);
    wr_sync = (phase_reg == rsf_pkg::RSF_PH_WRITE) &&
              (idx_reg == `RSF_IDX_SYNC);
    wr_resv = (phase_reg == rsf_pkg::RSF_PH_WRITE) &&
              (idx_reg == `RSF_IDX_RESV);
    wr_pat = (phase_reg == rsf_pkg::RSF_PH_WRITE) &&
             (idx_reg == `RSF_IDX_PAT);
  end

  // polyphase filter: centre frequency writable, low nibble fixed
  rsf_cfg_reg #(
    .W(8),
    .RESET_VAL(`RSF_RST_PFC),
    .WMASK(`RSF_WMASK_PFC)
  ) u_pfc (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .wr_en(wr_pfc),
    .wdata(hwdata[7:0]),
    .value_reg(polyphase_filter_config_reg)
  );

  // sync control: bit 0 reserved and held at zero
  rsf_cfg_reg #(
    .W(8),
    .RESET_VAL(`RSF_RST_SYNC),
    .WMASK(`RSF_WMASK_SYNC)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .wr_en(wr_sync),
    .wdata(hwdata[7:0]),
    .value_reg(sync_word_control_reg)
  );

  // reserved register: no bit is writable
  // kept as flops so that reads return its fixed image
  rsf_cfg_reg #(
    .W(8),
    .RESET_VAL(`RSF_RST_RESV),
    .WMASK(`RSF_WMASK_RESV)
  ) u_resv (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .wr_en(wr_resv),
    .wdata(hwdata[7:0]),
    .value_reg(reserved_config_reg)
  );

  // stored sync pattern, every bit writable
  // own extension: reference word for the detector only
  rsf_cfg_reg #(
    .W(PW),
    .RESET_VAL(PW'(`RSF_RST_PAT)),
    .WMASK({PW{1'b1}})
  ) u_pat (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .wr_en(wr_pat),
    .wdata(hwdata[PW-1:0]),
    .value_reg(sync_pattern_reg)
  );

  // read path
  // the config registers are one byte wide, so their upper lanes read zero; the pattern reads whole

  // read mux; unmapped words read zero, narrow regs zero-extended
  always_comb begin
    unique case (idx_reg)
      `RSF_IDX_PFC: hrdata_next = {24'h000000,
                                   polyphase_filter_config_reg};
      `RSF_IDX_SYNC: hrdata_next = {24'h000000, sync_word_control_reg};
      `RSF_IDX_RESV: hrdata_next = {24'h000000, reserved_config_reg};
      `RSF_IDX_PAT: hrdata_next = 32'(sync_pattern_reg);
      default: hrdata_next = 32'h0000_0000;
    endcase
  end

  // read data loaded at the end of the wait state; a write just
  // before a read has landed by then, so no forwarding is needed
  // hrdata then holds until the next read completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (ce && phase_reg == rsf_pkg::RSF_PH_READ) begin
      hrdata_reg <= hrdata_next;
    end
  end

  // ready drops for one cycle after a read address is taken
  // writes never stall, so only a read lowers it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
    end else if (ce) begin
      if (phase_reg == rsf_pkg::RSF_PH_READ) begin
        hreadyout_reg <= 1'b1;
      end else if (rd_take) begin
        hreadyout_reg <= 1'b0;
      end else begin
        hreadyout_reg <= 1'b1;
      end
    end
  end

  // every answer is okay, unmapped accesses included
  // no error path exists; unmapped words simply read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_reg <= `RSF_HRESP_OKAY;
    end else if (ce) begin
      hresp_reg <= `RSF_HRESP_OKAY;
    end
  end

  // configuration outputs
  // every port is a flop, so the rf path sees a change one edge late

  // centre frequency copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfv_out_reg <= PFC_RST[`RSF_PFC_CFV_HI:`RSF_PFC_CFV_LO];
    end else if (ce) begin
      cfv_out_reg <= polyphase_filter_config_reg[`RSF_PFC_CFV_HI:
                                                 `RSF_PFC_CFV_LO];
    end
  end

  // filter and synchronizer copies
  // raw bit kept as well, for users that want the register sense
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      polen_out_reg <= SYNC_RST[`RSF_SYNC_POLEN];
      bsoff_out_reg <= SYNC_RST[`RSF_SYNC_BSOFF];
      bsact_out_reg <= ~SYNC_RST[`RSF_SYNC_BSOFF];
    end else if (ce) begin
      polen_out_reg <= sync_word_control_reg[`RSF_SYNC_POLEN];
      bsoff_out_reg <= sync_word_control_reg[`RSF_SYNC_BSOFF];
      // a set control bit means the synchronizer is off
      bsact_out_reg <= ~sync_word_control_reg[`RSF_SYNC_BSOFF];
    end
  end

  // detector setting copies
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deton_out_reg <= SYNC_RST[`RSF_SYNC_DETON];
      len_out_reg <= SYNC_RST[`RSF_SYNC_LEN_HI:`RSF_SYNC_LEN_LO];
      tol_out_reg <= SYNC_RST[`RSF_SYNC_TOL_HI:`RSF_SYNC_TOL_LO];
    end else if (ce) begin
      deton_out_reg <= sync_word_control_reg[`RSF_SYNC_DETON];
      len_out_reg <= sync_word_control_reg[`RSF_SYNC_LEN_HI:
                                           `RSF_SYNC_LEN_LO];
      tol_out_reg <= sync_word_control_reg[`RSF_SYNC_TOL_HI:
                                           `RSF_SYNC_TOL_LO];
    end
  end

  // sync word detection
  // the detector runs on the bit stream, apart from the bus

  // compares live register fields so a change acts on the next bit
  // history is not cleared on enable, so earlier bits may count
  rsf_pattern_match #(
    .PW(PW)
  ) u_match (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .detect_on(sync_word_control_reg[`RSF_SYNC_DETON]),
    .length_sel(sync_word_control_reg[`RSF_SYNC_LEN_HI:
                                      `RSF_SYNC_LEN_LO]),
    .tolerance(sync_word_control_reg[`RSF_SYNC_TOL_HI:
                                     `RSF_SYNC_TOL_LO]),
    .pattern(sync_pattern_reg),
    .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid),
    .match_reg(pattern_match)
  );

  // port drive
  // nothing but wires here, so no output carries a glitch

  // bus answer, straight from flops
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

  // configuration fields, straight from flops
  assign poly_centre_freq_value = cfv_out_reg;
  assign ook_poly_filter_on = polen_out_reg;
  assign bit_synchronizer_off_n = bsoff_out_reg;
  assign bit_sync_active = bsact_out_reg;
  assign pattern_detect_on = deton_out_reg;
  assign pattern_length_sel = len_out_reg;
  assign pattern_error_tolerance = tol_out_reg;

endmodule : rsf_rx_sync_filter_config

// file: testbench/rsf_cfg_props.sv
// checker for the rx config bank bus timing and field copies
`timescale 1ns/1ps
`include "rsf_defs.svh"
module rsf_cfg_props #(
  parameter int AW = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic rx_bit_valid,
  input wire logic [3:0] poly_centre_freq_value,
  input wire logic ook_poly_filter_on,
  input wire logic bit_synchronizer_off_n,
  input wire logic bit_sync_active,
  input wire logic pattern_detect_on,
  input wire logic [1:0] pattern_length_sel,
  input wire logic [1:0] pattern_error_tolerance,
  input wire logic pattern_match
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // transfer accepted at this edge
  logic take;
  assign take = hsel && hready && htrans[1] && ce;
  // read address phase at a given index
  sequence rd_at(logic [7:0] idx);
    take && !hwrite && haddr[9:2] == idx;
  endsequence
  // write address phase then its data phase
  sequence wr_at(logic [7:0] idx);
    take && hwrite && haddr[9:2] == idx ##1 1'b1;
  endsequence
  // one wait cycle then ready
  sequence rd_done;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_one_wait: assert property (take && !hwrite |=> rd_done)
    else $error("read wait state count wrong");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_rdata_hold: assert property ($changed(hrdata) |->
    hreadyout && !$past(hreadyout)) else $error("read data moved");
  a_pfc_low_fixed: assert property (rd_at(`RSF_IDX_PFC) |->
    ##2 hrdata[3:0] == 4'h8) else $error("pfc low nibble wrong");
  a_sync_bit_zero: assert property (rd_at(`RSF_IDX_SYNC) |->
    ##2 hrdata[0] == 1'b0) else $error("sync bit 0 not zero");
  a_resv_fixed: assert property (rd_at(`RSF_IDX_RESV) |->
    ##2 hrdata == 32'h0000_0007) else $error("reserved reg changed");
  a_cfv_follows: assert property (wr_at(`RSF_IDX_PFC) |->
    ##2 poly_centre_freq_value == $past(hwdata[7:4], 2))
    else $error("centre freq output wrong");
  a_sync_fields: assert property (wr_at(`RSF_IDX_SYNC) |->
    ##2 {ook_poly_filter_on, bit_synchronizer_off_n, pattern_detect_on,
    pattern_length_sel, pattern_error_tolerance} == $past(hwdata[7:1], 2))
    else $error("sync field outputs wrong");
  a_sync_inverse: assert property (
    bit_sync_active == !bit_synchronizer_off_n)
    else $error("synchronizer state not inverse");
  a_match_after_bit: assert property (
    pattern_match |-> $past(rx_bit_valid)) else $error("match w/o bit");
  a_off_no_match: assert property (
    !pattern_detect_on && !$past(pattern_detect_on) |-> !pattern_match)
    else $error("match while detection off");
endmodule : rsf_cfg_props

bind rsf_rx_sync_filter_config rsf_cfg_props #(.AW(AW)) u_props (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .rx_bit_valid(rx_bit_valid),
  .poly_centre_freq_value(poly_centre_freq_value),
  .ook_poly_filter_on(ook_poly_filter_on),
  .bit_synchronizer_off_n(bit_synchronizer_off_n),
  .bit_sync_active(bit_sync_active), .pattern_detect_on(pattern_detect_on),
  .pattern_length_sel(pattern_length_sel),
  .pattern_error_tolerance(pattern_error_tolerance),
  .pattern_match(pattern_match));

// file: testbench/testbench.sv
// self-checking bench of the rx config bank
`timescale 1ns/1ps
`include "rsf_defs.svh"
module testbench;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic rx_bit, rx_bit_valid, filt, bs_off, bs_act, det, match;
  logic [11:0] haddr;
  logic [1:0] htrans, len, tol;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [3:0] cfv;
  int errors, cmp_count;
  // sync pattern stored for the match runs
  localparam logic [31:0] PAT = 32'ha5c3_96f1;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  rsf_rx_sync_filter_config uut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .poly_centre_freq_value(cfv),
    .ook_poly_filter_on(filt), .bit_synchronizer_off_n(bs_off),
    .bit_sync_active(bs_act), .pattern_detect_on(det),
    .pattern_length_sel(len), .pattern_error_tolerance(tol),
    .pattern_match(match));
  // 125 MHz clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic end_of_test;
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // bounded wait for ready sampled high at an edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      errors++;
      $display("ERROR %0t ready never came", $time);
      end_of_test();
    end
  endtask : wait_rdy
  // one single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {2'b00, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, `RSF_HRESP_OKAY}, "resp");
  endtask : bus
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(rd, e, "read");
  endtask : rd_chk
  // field outputs after their two-cycle lag
  task automatic fld_chk(input logic [11:0] e);
    repeat (3) @(posedge hclk);
    chk({cfv, filt, bs_off, bs_act, det, len, tol}, e, "fields");
  endtask : fld_chk
  task automatic t_reset;
    rd_chk(`RSF_IDX_PFC, 32'h38);
    rd_chk(`RSF_IDX_SYNC, 32'h18);
    rd_chk(`RSF_IDX_RESV, 32'h07);
    fld_chk(12'h32c);
  endtask : t_reset
  task automatic t_pfc;
    logic [7:0] v;
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h5a : 8'hff;
      bus(1'b1, `RSF_IDX_PFC, {24'h0, v});
      rd_chk(`RSF_IDX_PFC, {24'h0, v[7:4], 4'h8});
      fld_chk({v[7:4], 8'h2c});
    end
  endtask : t_pfc
  // clock enable low freezes the bank: a write then is lost
  task automatic t_ce;
    ce <= 1'b0;
    bus(1'b1, `RSF_IDX_PFC, 32'hc0);
    ce <= 1'b1;
    rd_chk(`RSF_IDX_PFC, 32'h58);
  endtask : t_ce
  // reset in mid-run brings every register back to its reset value
  task automatic t_rst_again;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
  endtask : t_rst_again
  task automatic t_sync;
    logic [7:0] v;
    for (int i = 0; i < 3; i++) begin
      v = i == 0 ? 8'hff : (i == 1 ? 8'h00 : 8'h4b);
      bus(1'b1, `RSF_IDX_SYNC, {24'h0, v});
      rd_chk(`RSF_IDX_SYNC, {24'h0, v & 8'hfe});
      fld_chk({4'h5, v[7:6], ~v[6], v[5:1]});
    end
  endtask : t_sync
  task automatic t_resv;
    bus(1'b1, `RSF_IDX_RESV, 32'hff);
    rd_chk(`RSF_IDX_RESV, 32'h07);
    bus(1'b1, 8'h14, 32'hff);
    rd_chk(8'h14, 32'h0);
  endtask : t_resv
  // feed the low n pattern bits, oldest first, some flipped
  task automatic send(input int n, input logic [31:0] m, input logic e);
    for (int i = n - 1; i >= 0; i--) begin
      rx_bit <= PAT[i] ^ m[i];
      rx_bit_valid <= 1'b1;
      @(posedge hclk);
    end
    rx_bit_valid <= 1'b0;
    @(posedge hclk);
    chk({31'h0, match}, {31'h0, e}, "match");
  endtask : send
  task automatic t_match;
    bus(1'b1, `RSF_IDX_PAT, PAT);
    for (int l = 0; l < 4; l++) begin
      for (int e = l; e < l + 2; e++) begin
        bus(1'b1, `RSF_IDX_SYNC, {26'h1, 2'(l), 2'(l), 1'b0});
        send(8 * (l + 1), (32'h1 << e) - 32'h1, e <= l);
      end
    end
    bus(1'b1, `RSF_IDX_SYNC, 32'h1e);
    send(32, 32'h0, 1'b0);
  endtask : t_match
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_pfc();
    t_ce();
    t_sync();
    t_resv();
    t_rst_again();
    t_match();
    end_of_test();
  end
  // hang guard, far beyond the expected run
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule : testbench
